// File: hw/bamr_regs.sv
`timescale 1ns/10ps
module bamr_regs
    import bamr_pkg::*;
#(
    parameter int TICK_CYCLES = ONE_SEC_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [15:0] cmdWdata,
    output logic [15:0]      rdData_r,
    output logic             rdValid_r,
    input  wire logic        initLoad,
    input  wire logic [15:0] nvCapThresh,
    input  wire logic [15:0] nvTimeThresh,
    input  wire logic        sleepEnter,
    input  wire logic        fullReset,
    input  wire logic        cycleCountInc,
    input  wire logic        fullChargeCapacityUpdate,
    input  wire logic        learnDone,
    input  wire logic [15:0] chargeLeftValue,
    input  wire logic [15:0] averagedTimeUntilEmpty,
    output logic             bcastReq_r,
    output logic [7:0]       bcastAddr_r,
    output logic [15:0]      bcastData_r,
    input  wire logic        bcastDone,
    output logic             chargeBcastEn_r,
    output logic             unitSelect_r,
    output logic             recomputeReq_r,
    output logic             rateRecomputePend_r,
    input  wire logic        rateWrite
);
    logic [15:0] capThr_r;
    logic [15:0] timeThr_r;
    logic        alarmSup_r;
    logic        chgSup_r;
    logic        relearn_r;
    logic [4:0]  relearnCnt_r;
    logic [6:0]  supCnt_r;
    logic        supRun_r;
    logic [6:0]  gapCnt_r;
    logic        capAlarm_r;
    logic        timeAlarm_r;
    bamr_bcast_t bcState_r;
    bamr_bcast_t bcState_nxt;
    logic        tick;

    bamr_tick #(.TICK_CYCLES(TICK_CYCLES)) secTick (
        .mclk  (mclk),
        .reset (reset),
        .clkEn (clkEn),
        .tick_r(tick)
    );

    wire        wrCap    = cmdValid && cmdWrite && (cmdCode == REG_LOW_CAP);
    wire        wrTime   = cmdValid && cmdWrite && (cmdCode == REG_LOW_TIME);
    wire        wrMode   = cmdValid && cmdWrite && (cmdCode == REG_MODE);
    wire        rdReq    = cmdValid && !cmdWrite;
    // Unused bits 0-6, 8-12 held at zero; bit 7 from relearn logic only
    wire [15:0] modeWord = {unitSelect_r, chgSup_r, alarmSup_r, 5'h00,    // [RL9] [RL11] [RL23]
                            relearn_r, 7'h00};                           // [RL8]
    wire [15:0] rdMux    = (cmdCode == REG_LOW_CAP)  ? capThr_r  :
                           (cmdCode == REG_LOW_TIME) ? timeThr_r :
                           (cmdCode == REG_MODE)     ? modeWord  : 16'h0000;
    // Threshold compare is unit-agnostic: both sides share the unit bit
    wire        capCond  = (capThr_r != 16'h0000) && (chargeLeftValue < capThr_r);  // [RL1] [RL2] [RL4]
    wire        timeCond = (timeThr_r != 16'h0000)
                           && (averagedTimeUntilEmpty < timeThr_r);              // [RL5] [RL6]
    wire        supExpire = supRun_r && tick && (supCnt_r == SUPPRESS_TICKS - 7'h01);
    wire        gapDone  = (gapCnt_r == 7'h00);
    wire        anyAlarm = capAlarm_r || timeAlarm_r;
    wire        unitNxt  = sleepEnter ? 1'b0 : wrMode ? cmdWdata[MODE_UNIT] : unitSelect_r;
    wire [15:0] alarmWord = (16'h0001 << STAT_CAP_ALARM) & {16{capAlarm_r}}
                          | (16'h0001 << STAT_TIME_ALARM) & {16{timeAlarm_r}};

    // Register reads answer one cycle after the request
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdData_r  <= 16'h0000;
            rdValid_r <= 1'b0;
        end else if (clkEn) begin
            rdValid_r <= rdReq;
            if (rdReq) begin
                rdData_r <= rdMux;
            end
        end
    end

    // Thresholds: init load, then host writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            capThr_r  <= THRESH_RESET;
            timeThr_r <= THRESH_RESET;
        end else if (clkEn) begin
            if (wrCap) begin
                capThr_r <= cmdWdata;                                   // [RL4]
            end else if (initLoad) begin
                capThr_r <= nvCapThresh;                                // [RL3]
            end
            if (wrTime) begin
                timeThr_r <= cmdWdata;                                  // [RL6]
            end else if (initLoad) begin
                timeThr_r <= nvTimeThresh;                              // [RL7]
            end
        end
    end

    // Writable bits 13-15 of the mode word
    always_ff @(posedge mclk) begin
        if (reset) begin
            alarmSup_r   <= 1'b0;
            chgSup_r     <= 1'b0;
            unitSelect_r <= 1'b0;
        end else if (clkEn) begin
            unitSelect_r <= unitNxt;                                    // [RL20] [RL17]
            if (sleepEnter) begin
                alarmSup_r <= 1'b0;                                     // [RL17]
                chgSup_r   <= 1'b0;
            end else if (wrMode) begin
                alarmSup_r <= cmdWdata[MODE_ALARM_SUP];                 // [RL12] [RL8]
                chgSup_r   <= cmdWdata[MODE_CHG_SUP];                   // [RL19]
            end else if (supExpire) begin
                alarmSup_r <= 1'b0;                                     // [RL15]
            end
        end
    end

    // Suppress timer, restarted by every mode write
    always_ff @(posedge mclk) begin
        if (reset) begin
            supCnt_r <= 7'h00;
            supRun_r <= 1'b0;
        end else if (clkEn) begin
            if (wrMode) begin
                supCnt_r <= 7'h00;                                      // [RL15]
                supRun_r <= 1'b1;
            end else if (sleepEnter || supExpire) begin
                supCnt_r <= 7'h00;
                supRun_r <= 1'b0;
            end else if (supRun_r && tick) begin
                supCnt_r <= supCnt_r + 7'h01;                           // [RL13]
            end
        end
    end

    // Relearn request: set beats clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            relearn_r    <= 1'b1;
            relearnCnt_r <= 5'h00;
        end else if (clkEn) begin
            if (fullChargeCapacityUpdate || fullReset) begin
                relearnCnt_r <= 5'h00;
            end else if (cycleCountInc && relearnCnt_r != RELEARN_CYCLES) begin
                relearnCnt_r <= relearnCnt_r + 5'h01;
            end
            if (fullReset || (relearnCnt_r == RELEARN_CYCLES)) begin
                relearn_r <= 1'b1;                                      // [RL10]
            end else if (learnDone) begin
                relearn_r <= 1'b0;                                      // [RL10]
            end
        end
    end

    // Alarm conditions and charging broadcast enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            capAlarm_r      <= 1'b0;
            timeAlarm_r     <= 1'b0;
            chargeBcastEn_r <= 1'b1;
        end else if (clkEn) begin
            capAlarm_r      <= capCond;                                 // [RL1]
            timeAlarm_r     <= timeCond;                                // [RL5]
            chargeBcastEn_r <= !chgSup_r;                               // [RL19] [RL18]
        end
    end

    // Unit change recompute strobes
    always_ff @(posedge mclk) begin
        if (reset) begin
            recomputeReq_r      <= 1'b0;
            rateRecomputePend_r <= 1'b0;
        end else if (clkEn) begin
            recomputeReq_r <= (unitNxt != unitSelect_r);                // [RL21]
            if (unitNxt != unitSelect_r) begin
                rateRecomputePend_r <= 1'b1;                            // [RL21]
            end else if (rateWrite || tick) begin
                rateRecomputePend_r <= 1'b0;
            end
        end
    end

    // Broadcast sequencer: host first, then charger
    always_comb begin
        bcState_nxt = bcState_r;
        case (bcState_r)
            BC_IDLE: begin
                if (anyAlarm && !alarmSup_r && gapDone) begin           // [RL12] [RL14]
                    bcState_nxt = BC_HOST;
                end
            end
            BC_HOST: begin
                if (alarmSup_r) begin
                    bcState_nxt = BC_IDLE;                              // [RL13]
                end else if (bcastDone) begin
                    bcState_nxt = BC_CHARGER;
                end
            end
            BC_CHARGER: begin
                if (alarmSup_r || bcastDone) begin
                    bcState_nxt = BC_IDLE;
                end
            end
            default: bcState_nxt = BC_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            bcState_r   <= BC_IDLE;
            bcastReq_r  <= 1'b0;
            bcastAddr_r <= ADDR_HOST;
            bcastData_r <= 16'h0000;
        end else if (clkEn) begin
            bcState_r  <= bcState_nxt;
            bcastReq_r <= (bcState_nxt != BC_IDLE) && !(bcastDone && bcastReq_r
                          && bcState_nxt == bcState_r);
            if (bcState_nxt == BC_CHARGER) begin
                bcastAddr_r <= ADDR_CHARGER;                            // [RL22]
            end else begin
                bcastAddr_r <= ADDR_HOST;                               // [RL22]
            end
            if (bcState_r == BC_IDLE && bcState_nxt == BC_HOST) begin
                bcastData_r <= alarmWord;                               // [RL1] [RL5]
            end
        end
    end

    // Spacing between alarm broadcasts, counted in whole seconds
    always_ff @(posedge mclk) begin
        if (reset) begin
            gapCnt_r <= 7'h00;
        end else if (clkEn) begin
            if (bcState_r == BC_IDLE && bcState_nxt == BC_HOST) begin
                gapCnt_r <= GAP_TICKS;                                  // [RL14]
            end else if (tick && !gapDone) begin
                gapCnt_r <= gapCnt_r - 7'h01;
            end
        end
    end

    zero_cap_a: assert property (@(posedge mclk) disable iff (reset)   // [RL2]
        clkEn && capThr_r == 16'h0000 |=> !capAlarm_r)
        else $error("capacity alarm with zero threshold");

    mode_fixed_a: assert property (@(posedge mclk) disable iff (reset) // [RL9] [RL11]
        rdValid_r && $past(cmdCode) == REG_MODE |-> rdData_r[12:8] == 5'h00
        && rdData_r[6:0] == 7'h00)
        else $error("fixed mode bits not zero");

    no_bcast_sup_a: assert property (@(posedge mclk) disable iff (reset) // [RL13]
        alarmSup_r && bcState_r == BC_IDLE |=> !bcastReq_r)
        else $error("broadcast while suppressed");

    sleep_clear_a: assert property (@(posedge mclk) disable iff (reset) // [RL17]
        clkEn && sleepEnter |=> modeWord[15:13] == 3'h0)
        else $error("sleep did not clear mode bits");

    relearn_set_a: assert property (@(posedge mclk) disable iff (reset) // [RL10]
        clkEn && fullReset |=> relearn_r)
        else $error("full reset did not request relearn");

    timer_restart_a: assert property (@(posedge mclk) disable iff (reset) // [RL15]
        clkEn && wrMode |=> supRun_r && supCnt_r == 7'h00)
        else $error("mode write did not restart timer");

    bcast_gap_a: assert property (@(posedge mclk) disable iff (reset)  // [RL14]
        clkEn && bcState_r == BC_IDLE && bcState_nxt == BC_HOST
        |-> gapCnt_r == 7'h00)
        else $error("broadcast started inside gap");

    init_load_a: assert property (@(posedge mclk) disable iff (reset)  // [RL3] [RL7]
        clkEn && initLoad && !wrCap && !wrTime
        |=> capThr_r == $past(nvCapThresh) && timeThr_r == $past(nvTimeThresh))
        else $error("init load not taken");

    unit_refresh_a: assert property (@(posedge mclk) disable iff (reset) // [RL21]
        clkEn && $changed(unitSelect_r) |-> recomputeReq_r)
        else $error("unit change without recompute");

    chg_indep_a: assert property (@(posedge mclk) disable iff (reset)  // [RL18] [RL19]
        clkEn ##1 clkEn |-> chargeBcastEn_r == !$past(chgSup_r))
        else $error("charging broadcast enable wrong");

    host_first_a: assert property (@(posedge mclk) disable iff (reset) // [RL22]
        clkEn && bcState_r == BC_IDLE && bcState_nxt == BC_HOST
        |=> bcastReq_r && bcastAddr_r == ADDR_HOST)
        else $error("broadcast did not open to host");

    sup_abort_a: assert property (@(posedge mclk) disable iff (reset)  // [RL12] [RL13]
        clkEn && alarmSup_r && bcState_r != BC_IDLE |=> !bcastReq_r)
        else $error("suppress did not abort broadcast");

    expire_clear_a: assert property (@(posedge mclk) disable iff (reset) // [RL15]
        clkEn && supExpire && !wrMode |=> !alarmSup_r)
        else $error("timer expiry did not clear suppress");
endmodule // bamr_regs

// File: hw/bamr_pkg.sv
// Functional notes
// RL1: Charge left below low-capacity threshold raises capacity-alarm warnings.
// RL2: Zero low-capacity threshold disables the capacity alarm.
// RL3: Low-capacity threshold loads from nonvolatile bytes 0x02-0x03 at init.
// RL4: Low-capacity threshold is unsigned 16 bits, mAh or 10 mWh by unit bit.
// RL5: Averaged time until empty below time threshold raises time-alarm warnings.
// RL6: Zero time threshold disables time alarm; full 16-bit minute range.
// RL7: Time threshold loads from nonvolatile bytes 0x00-0x01 at init.
// RL8: Mode word upper byte host-writable, lower byte read-only; the code stores only bits 13-15, bits 8-12 read zero.
// RL9: Mode bits 0-6 read zero; host writes to bit 7 ignored.
// RL10: Relearn flag set on full reset or 20 cycle counts without update.
// RL11: Mode bits 8 and 9 always read zero.
// RL12: Alarm-suppress bit 13 clear sends warnings to host and charger.
// RL13: Once suppress set, no alarm bus mastering for 59 to 60 s.
// RL14: Alarm broadcasts spaced at least 10 s apart.
// RL15: Each mode write restarts 60 s timer; expiry clears suppress bit.
// RL16: Host rewrites suppress bit at most every 59 s to keep silence.
// RL17: Sleep entry clears suppress, charging-suppress and unit-select bits.
// RL18: Alarm suppress and its timer leave charging broadcasts untouched.
// RL19: Bit 14 set stops charging current and voltage broadcasts.
// RL20: Bit 15 selects mA/mAh or 10 mW/10 mWh units.
// RL21: Unit change triggers recompute within 1 s; rate results on next rate.
// RL22: Broadcasts use write word; charger at 0x12, host at 0x10.
// RL23: Reserved mode bits 10-12 read zero, writes ignored.
package bamr_pkg;
    localparam logic [7:0]  REG_LOW_CAP      = 8'h01;
    localparam logic [7:0]  REG_LOW_TIME     = 8'h02;
    localparam logic [7:0]  REG_MODE         = 8'h03;
    localparam logic [7:0]  NV_CAP_OFFSET    = 8'h02;
    localparam logic [7:0]  NV_TIME_OFFSET   = 8'h00;
    localparam int          MODE_RELEARN     = 7;
    localparam int          MODE_ALARM_SUP   = 13;
    localparam int          MODE_CHG_SUP     = 14;
    localparam int          MODE_UNIT        = 15;
    localparam logic [15:0] THRESH_RESET     = 16'h0000;
    localparam logic [7:0]  ADDR_HOST        = 8'h10;
    localparam logic [7:0]  ADDR_CHARGER     = 8'h12;
    localparam int          STAT_CAP_ALARM   = 9;
    localparam int          STAT_TIME_ALARM  = 8;
    localparam logic [4:0]  RELEARN_CYCLES   = 5'h14;
    localparam longint      CLK_PERIOD_PS    = 4000;
    localparam longint      PS_PER_S         = 64'd1000000000000;
    localparam int          TICK_PERIOD_S    = 1;
    localparam int          ONE_SEC_CYCLES   = int'(PS_PER_S * TICK_PERIOD_S / CLK_PERIOD_PS);
    localparam int          SUPPRESS_MAX_S   = 60;
    localparam logic [6:0]  SUPPRESS_TICKS   = 7'(SUPPRESS_MAX_S / TICK_PERIOD_S);
    localparam int          BCAST_GAP_S      = 10;
    localparam logic [6:0]  GAP_TICKS        = 7'(BCAST_GAP_S / TICK_PERIOD_S + 1);
    typedef enum logic [1:0] {BC_IDLE, BC_HOST, BC_CHARGER} bamr_bcast_t;
endpackage

// File: hw/bamr_tick.sv
`timescale 1ns/10ps
module bamr_tick
    import bamr_pkg::*;
#(
    parameter int TICK_CYCLES = ONE_SEC_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic clkEn,
    output logic      tick_r
);
    logic [31:0] cnt_r;
    wire         wrap = (cnt_r == 32'(TICK_CYCLES - 1));

    // Free-running one second strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_r  <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (clkEn) begin
            cnt_r  <= wrap ? 32'h00000000 : cnt_r + 32'h00000001;
            tick_r <= wrap;
        end
    end
endmodule // bamr_tick

// File: sim/bamr_bus_model.sv
`timescale 1ns/10ps
module bamr_bus_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       bcastReq_r,
    input  wire logic [1:0] stall,
    output logic            bcastDone
);
    logic [1:0] cnt_r;
    // Write word to host 0x10 or charger 0x12, one done per destination
    always_ff @(posedge mclk) begin
        if (reset || !bcastReq_r || bcastDone) begin
            cnt_r     <= 2'h0;
            bcastDone <= 1'b0;
        end else if (cnt_r >= stall) begin
            bcastDone <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule // bamr_bus_model

// File: sim/battery_alarm_mode_regs_tb.sv
`timescale 1ns/10ps
module battery_alarm_mode_regs_tb;
    import bamr_pkg::*;
    localparam int TK = 20;
    logic        mclk = 1'b0, reset = 1'b1, clkEn = 1'b1;
    logic        cmdValid = 1'b0, cmdWrite = 1'b0;
    logic [7:0]  cmdCode = 8'h00;
    logic [15:0] cmdWdata = 16'h0000, nvCap = 16'h0000, nvTime = 16'h0000;
    logic        initLoad = 1'b0, sleepEnter = 1'b0, fullReset = 1'b0, cycInc = 1'b0;
    logic        fccUpd = 1'b0, learnDone = 1'b0, rateWrite = 1'b0;
    logic [15:0] chargeLeft = 16'hffff, avgTte = 16'hffff;
    logic [15:0] rdData_r, bcastData_r, lastData, rv, d;
    logic [7:0]  bcastAddr_r, lastAddr;
    logic        rdValid_r, bcastReq_r, bcastDone, chargeBcastEn_r, unitSelect_r;
    logic        recomputeReq_r, ratePend_r, recSeen = 1'b0, pendSeen = 1'b0;
    logic        noBcast = 1'b0, reqPrev = 1'b0;
    logic [1:0]  stall = 2'h0;
    int          fails = 0, total_checks = 0, cyc = 0, lastStart = -100000, nDeliv = 0;
    int          seed = 32'hec80d4f8;

    always #2 mclk = ~mclk;

    bamr_regs #(.TICK_CYCLES(TK)) dut (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
        .rdData_r(rdData_r), .rdValid_r(rdValid_r), .initLoad(initLoad),
        .nvCapThresh(nvCap), .nvTimeThresh(nvTime), .sleepEnter(sleepEnter),
        .fullReset(fullReset), .cycleCountInc(cycInc), .fullChargeCapacityUpdate(fccUpd),
        .learnDone(learnDone), .chargeLeftValue(chargeLeft), .averagedTimeUntilEmpty(avgTte),
        .bcastReq_r(bcastReq_r), .bcastAddr_r(bcastAddr_r), .bcastData_r(bcastData_r),
        .bcastDone(bcastDone), .chargeBcastEn_r(chargeBcastEn_r),
        .unitSelect_r(unitSelect_r), .recomputeReq_r(recomputeReq_r),
        .rateRecomputePend_r(ratePend_r), .rateWrite(rateWrite));

    bamr_bus_model partner (
        .mclk(mclk), .reset(reset), .bcastReq_r(bcastReq_r), .stall(stall),
        .bcastDone(bcastDone));

    function automatic logic [15:0] modeExp(input logic [15:0] w, input logic rl);
        return {w[15:13], 5'h00, rl, 7'h00};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        @(negedge mclk);
        cmdValid = 1'b1; cmdWrite = 1'b1; cmdCode = c; cmdWdata = v;
        @(negedge mclk);
        cmdValid = 1'b0; cmdWrite = 1'b0;
    endtask

    task automatic rchk(input logic [7:0] c, input logic [15:0] e, input string nm);
        int n;
        @(negedge mclk);
        cmdValid = 1'b1; cmdWrite = 1'b0; cmdCode = c;
        @(negedge mclk);
        cmdValid = 1'b0;
        n = 0;
        while (rdValid_r !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        chk(nm, e, rdData_r);
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    task automatic incN(input int n);
        repeat (n) pulse(cycInc);
    endtask

    task automatic waitDeliv(input int n);
        int k;
        k = 0;
        while (nDeliv < n && k < 30 * TK) begin
            @(negedge mclk);
            k++;
        end
        chk("deliveries", 1, 16'(nDeliv >= n));
    endtask

    task automatic idle;
        repeat (2) @(negedge mclk);
        while (bcastReq_r !== 1'b0) @(negedge mclk);
        repeat (2) @(negedge mclk);
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        reqPrev <= bcastReq_r;
        if (recomputeReq_r) recSeen <= 1'b1;
        if (ratePend_r) pendSeen <= 1'b1;
        if (cyc > 20000) begin
            fails++;
            stop_test();
        end
        if (bcastReq_r && !reqPrev) begin
            chk("bcast gap", 1, 16'(cyc - lastStart >= 10 * TK));
            chk("first addr", ADDR_HOST, 16'(bcastAddr_r));
            lastStart <= cyc;
        end
        if (noBcast && bcastReq_r) chk("silent req", 0, 1);
        if (bcastReq_r && bcastDone) begin
            nDeliv <= nDeliv + 1;
            lastAddr <= bcastAddr_r;
            lastData <= bcastData_r;
        end
    end

    initial begin
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        rchk(REG_MODE, 16'h0080, "mode rst");
        rchk(8'h09, 16'h0000, "unmapped");
        nvCap = 16'($random(seed));
        nvTime = 16'($random(seed));
        pulse(initLoad);
        rchk(REG_LOW_CAP, nvCap, "cap init");
        rchk(REG_LOW_TIME, nvTime, "time init");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'hffff : 16'($random(seed));
            wr(REG_LOW_CAP + 8'(i % 2), d);
            wr(8'h05, ~d);
            rchk(REG_LOW_CAP + 8'(i % 2), d, "thresh rw");
        end
        @(negedge mclk);
        clkEn = 1'b0;
        wr(REG_LOW_TIME, ~d);
        clkEn = 1'b1;
        rchk(REG_LOW_TIME, d, "frozen");
        wr(REG_MODE, 16'hffff);
        rchk(REG_MODE, 16'he080, "mode ro");
        chk("unit", 1, unitSelect_r);
        chk("chg bcast", 0, chargeBcastEn_r);
        chk("recompute", 1, recSeen);
        chk("rate pend", 1, pendSeen);
        pulse(rateWrite);
        chk("rate clr", 0, ratePend_r);
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            wr(REG_MODE, d);
            rchk(REG_MODE, modeExp(d, 1'b1), "mode rand");
            chk("chg en", !d[14], chargeBcastEn_r);
            chk("unit sel", d[15], unitSelect_r);
        end
        pulse(learnDone);
        rchk(REG_MODE, modeExp(d, 1'b0), "relearn clr");
        incN(10);
        pulse(fccUpd);
        incN(19);
        rchk(REG_MODE, modeExp(d, 1'b0), "relearn 19");
        incN(1);
        rchk(REG_MODE, modeExp(d, 1'b1), "relearn 20");
        pulse(fccUpd);
        pulse(learnDone);
        pulse(fullReset);
        rchk(REG_MODE, modeExp(d, 1'b1), "relearn full");
        wr(REG_MODE, 16'he000);
        pulse(sleepEnter);
        rchk(REG_MODE, 16'h0080, "sleep");
        chk("sleep unit", 0, unitSelect_r);
        stall = 2'($random(seed));
        wr(REG_LOW_TIME, 16'h0000);
        wr(REG_LOW_CAP, 16'h0064);
        chargeLeft = 16'h0063;
        waitDeliv(nDeliv + 2);
        chk("cap bit", 1, lastData[STAT_CAP_ALARM]);
        chk("last addr", ADDR_CHARGER, lastAddr);
        repeat (25 * TK) @(negedge mclk);
        wr(REG_LOW_CAP, 16'h0000);
        idle();
        noBcast = 1'b1;
        repeat (15 * TK) @(negedge mclk);
        noBcast = 1'b0;
        stall = 2'($random(seed));
        wr(REG_LOW_TIME, 16'h0010);
        avgTte = 16'h000f;
        waitDeliv(nDeliv + 2);
        chk("time bit", 1, lastData[STAT_TIME_ALARM]);
        chk("cap off", 0, lastData[STAT_CAP_ALARM]);
        idle();
        wr(REG_MODE, 16'h2000);
        noBcast = 1'b1;
        repeat (30 * TK) @(negedge mclk);
        wr(REG_MODE, 16'h2000);
        repeat (58 * TK) @(negedge mclk);
        rchk(REG_MODE, 16'h2080, "sup held");
        chk("chg kept", 1, chargeBcastEn_r);
        repeat (TK - 8) @(negedge mclk);
        noBcast = 1'b0;
        repeat (2 * TK + 8) @(negedge mclk);
        rchk(REG_MODE, 16'h0080, "sup expiry");
        waitDeliv(nDeliv + 1);
        stop_test();
    end
endmodule // battery_alarm_mode_regs_tb
